// [hdl/dcm_comparator.sv]
// debug comparator with apb register slave and match pulse
`timescale 1ns/10ps
module dcm_comparator #(
  parameter logic [31:0] MATCH_ADDR = 32'h0000_0000
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 dbg_armed,
  input  wire logic                 trace_active_flag,
  input  wire dcm_pkg::dcm_access_s bus_acc,
  output logic                      match_pulse
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [31:0] data_reg, data_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        match_reg, match_next;
  logic        wr_ok, acc_phase, hit_ctrl, hit_data, hit_mask;
  logic [31:0] cmp_mask, diff;
  logic        dir_ok, data_eq, data_ok, addr_ok;

  // decode of the access phase
  assign acc_phase = psel && penable && !pready_reg;
  assign hit_ctrl  = paddr == dcm_pkg::CTRL_OFFS;
  assign hit_data  = paddr == dcm_pkg::DATA_OFFS;
  assign hit_mask  = paddr == dcm_pkg::MASK_OFFS;
  assign wr_ok     = !dbg_armed && !trace_active_flag;

  // ****************************************
  // register file next state
  // ****************************************
  always_comb begin
    ctrl_next    = ctrl_reg;
    data_next    = data_reg;
    mask_next    = mask_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (acc_phase) begin
      pready_next  = 1'b1;
      pslverr_next = !(hit_ctrl || hit_data || hit_mask);
      if (pwrite) begin
        if (wr_ok && hit_ctrl && pstrb[0]) begin
          ctrl_next = pwdata[7:0] & dcm_pkg::CTRL_WMASK;
        end
        for (int b = 0; b < 4; b++) begin
          if (wr_ok && pstrb[b] && hit_data) begin
            data_next[8*b +: 8] = pwdata[8*b +: 8];
          end
          if (wr_ok && pstrb[b] && hit_mask) begin
            mask_next[8*b +: 8] = pwdata[8*b +: 8];
          end
        end
      end else begin
        // reads are allowed at any time
        if (hit_ctrl) begin
          prdata_next = {24'h00_0000, ctrl_reg};
        end else if (hit_data) begin
          prdata_next = data_reg;
        end else if (hit_mask) begin
          prdata_next = mask_reg;
        end else begin
          prdata_next = 32'h0000_0000;
        end
      end
    end
  end

  // register file state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= dcm_pkg::CTRL_RST;
      data_reg    <= dcm_pkg::DATA_RST;
      mask_reg    <= dcm_pkg::MASK_RST;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      ctrl_reg    <= ctrl_next;
      data_reg    <= data_next;
      mask_reg    <= mask_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ****************************************
  // match evaluation
  // ****************************************
  // narrow accesses only look at the low half
  assign cmp_mask = bus_acc.narrow ?
                    {{(32-dcm_pkg::NARROW_W){1'b0}}, mask_reg[dcm_pkg::NARROW_W-1:0]} :
                    mask_reg;
  assign diff     = (bus_acc.data ^ data_reg) & cmp_mask;
  assign data_eq  = diff == 32'h0000_0000;
  assign data_ok  = ctrl_reg[dcm_pkg::MISMATCH_BIT] ? !data_eq : data_eq;
  assign dir_ok   = !ctrl_reg[dcm_pkg::DIR_CHK_BIT] ||
                    (bus_acc.read == ctrl_reg[dcm_pkg::DIR_READ_BIT]);
  assign addr_ok  = bus_acc.addr == MATCH_ADDR;

  // combine qualifiers into the next match value
  always_comb begin
    match_next = 1'b0;
    if (ctrl_reg[dcm_pkg::COMP_EN_BIT] && bus_acc.valid && addr_ok) begin
      if (ctrl_reg[dcm_pkg::PC_SEL_BIT]) begin
        match_next = bus_acc.pc_fetch;
      end else begin
        match_next = !bus_acc.pc_fetch && dir_ok && data_ok;
      end
    end
  end

  // registered one cycle match pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_reg <= 1'b0;
    end else if (clk_en) begin
      match_reg <= match_next;
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign match_pulse = match_reg;

  // ****************************************
  // assertions
  // ****************************************
  ctrl_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && (dbg_armed || trace_active_flag)) |=> $stable(ctrl_reg))
    else $error("control changed while locked");
  data_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && (dbg_armed || trace_active_flag)) |=> $stable(data_reg))
    else $error("data changed while locked");
  mask_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && (dbg_armed || trace_active_flag)) |=> $stable(mask_reg))
    else $error("mask changed while locked");
  disabled_nomatch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !ctrl_reg[dcm_pkg::COMP_EN_BIT]) |=> !match_pulse)
    else $error("match while disabled");
  pc_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl_reg[0] && ctrl_reg[5] && bus_acc.valid && bus_acc.pc_fetch
     && addr_ok) |=> match_pulse)
    else $error("pc match missed");
  dir_filter_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !ctrl_reg[5] && ctrl_reg[2] && bus_acc.read != ctrl_reg[3])
    |=> !match_pulse)
    else $error("wrong direction matched");
  eq_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl_reg[0] && !ctrl_reg[5] && !ctrl_reg[2] && !ctrl_reg[6]
     && bus_acc.valid && !bus_acc.pc_fetch && addr_ok && diff == 32'h0)
    |=> match_pulse)
    else $error("equal data match missed");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && pready) |=> !pready)
    else $error("pready held over two cycles");
  cov_write_c: cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && pwrite && hit_ctrl);
  cov_pc_c: cover property (@(posedge pclk) disable iff (!presetn)
    match_pulse && ctrl_reg[5]);
  cov_neq_c: cover property (@(posedge pclk) disable iff (!presetn)
    match_pulse && ctrl_reg[6] && !ctrl_reg[5]);
endmodule // dcm_comparator

// [inc/dcm_pkg.sv]
// package for the debug comparator match block
package dcm_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL_OFFS = 12'h110;
  localparam logic [11:0] DATA_OFFS = 12'h138;
  localparam logic [11:0] MASK_OFFS = 12'h13c;
  // ****************************************
  // control field positions
  // ****************************************
  localparam int COMP_EN_BIT  = 0;
  localparam int DIR_CHK_BIT  = 2;
  localparam int DIR_READ_BIT = 3;
  localparam int PC_SEL_BIT   = 5;
  localparam int MISMATCH_BIT = 6;
  localparam logic [7:0]  CTRL_WMASK = 8'h6d;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [31:0] DATA_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;
  localparam int NARROW_W = 16;
  // ****************************************
  // bus access carrier
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic        pc_fetch;
    logic        read;
    logic        narrow;
    logic [31:0] addr;
    logic [31:0] data;
  } dcm_access_s;
endpackage

// [testbench/dcm_bus_model.sv]
// bus side model feeding access records to the comparator
`timescale 1ns/10ps
module dcm_bus_model (
  input  wire logic                 pclk,
  input  wire dcm_pkg::dcm_access_s req,
  output dcm_pkg::dcm_access_s      bus_acc
);
  // registered access; idle data flips so no stale value shows
  always_ff @(posedge pclk) begin
    bus_acc <= {req[$bits(req)-1:32], (req.valid ? req.data : ~bus_acc.data)};
  end
endmodule // dcm_bus_model

// [testbench/tb_dcm_comparator.sv]
// self-checking bench for the debug comparator
`timescale 1ns/10ps
module tb_dcm_comparator;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam logic [31:0] MADDR = 32'h0000_1234;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                 armed, trace, match_pulse, exp_m, err, clk_en;
  logic [11:0]          paddr;
  logic [3:0]           pstrb;
  logic [31:0]          pwdata, prdata, rd, ctrl_m, data_m, mask_m;
  int                   fails, cmp_count;
  dcm_pkg::dcm_access_s req, bus_acc;
  logic [7:0]           modes [10] = '{8'h00, 8'h01, 8'h05, 8'h0d, 8'h21, 8'h25, 8'h41,
                                       8'h45, 8'h4d, 8'h6d};
  dcm_comparator #(.MATCH_ADDR(MADDR)) dcm_comparator_pc_address_select (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dbg_armed(armed), .trace_active_flag(trace), .bus_acc(bus_acc),
    .match_pulse(match_pulse));
  dcm_bus_model dcm_bus_model_pc_address_select (.pclk(pclk), .req(req), .bus_acc(bus_acc));
  // ****************************************
  // reference model and compares
  // ****************************************
  function automatic logic f_match(dcm_pkg::dcm_access_s a);
    logic [31:0] d;
    d = (a.data ^ data_m) & mask_m & (a.narrow ? 32'h0000_ffff : 32'hffff_ffff);
    if (!ctrl_m[0] || !a.valid || a.addr !== MADDR) return 1'b0;
    if (ctrl_m[5]) return a.pc_fetch;
    if (a.pc_fetch || (ctrl_m[2] && a.read != ctrl_m[3])) return 1'b0;
    return ctrl_m[6] ? (d != 0) : (d == 0);
  endfunction
  task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(string n, logic e, logic g);
    cmp_word(n, {31'h0, e}, {31'h0, g});
  endtask
  // expected pulse follows each access by one cycle
  always @(posedge pclk) exp_m <= clk_en ? f_match(bus_acc) : exp_m;
  always @(negedge pclk) cmp_bit("match", exp_m, match_pulse);
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // answer is settled mid-cycle; it is taken at this falling edge, before the coming rising edge
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fails++;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    apb(1'b1, a, d, s);
    cmp_bit("wr_err", 1'b0, err);
    if (armed || trace) return;
    if (a == dcm_pkg::CTRL_OFFS) bm = bm & {24'h0, dcm_pkg::CTRL_WMASK};
    if (a == dcm_pkg::CTRL_OFFS) ctrl_m = (ctrl_m & ~bm) | (d & bm);
    if (a == dcm_pkg::DATA_OFFS) data_m = (data_m & ~bm) | (d & bm);
    if (a == dcm_pkg::MASK_OFFS) mask_m = (mask_m & ~bm) | (d & bm);
  endtask
  task automatic rdchk(logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    cmp_word("rdata", e, rd);
  endtask
  task automatic traffic(int cycles);
    repeat (cycles) begin
      @(posedge pclk);
      clk_en <= $urandom_range(0, 7) != 0;
      req.valid <= $urandom_range(0, 3) != 0;
      req.pc_fetch <= $urandom_range(0, 1);
      req.read <= $urandom_range(0, 1);
      req.narrow <= $urandom_range(0, 1);
      req.addr <= ($urandom_range(0, 3) != 0) ? MADDR : $urandom;
      req.data <= data_m ^ ($urandom_range(0, 1) ? 32'h0 : 32'h1 << $urandom_range(0, 31));
    end
    @(posedge pclk);
    req.valid <= 1'b0;
    clk_en <= 1'b1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
  initial begin
    void'($urandom(31001));
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, armed, trace} = '0;
    {req, ctrl_m, data_m, mask_m, fails, cmp_count} = '0;
    clk_en = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(dcm_pkg::CTRL_OFFS, 32'h0);
    rdchk(dcm_pkg::DATA_OFFS, 32'h0);
    rdchk(dcm_pkg::MASK_OFFS, 32'h0);
    apb(1'b0, 12'h114, 32'h0, 4'h0);
    cmp_bit("slverr", 1'b1, err);
    $display("test reset done");
    wr(dcm_pkg::DATA_OFFS, 32'hffff_ffff, 4'h8);
    rdchk(dcm_pkg::DATA_OFFS, 32'hff00_0000);
    wr(dcm_pkg::MASK_OFFS, 32'h1234_5678, 4'h3);
    rdchk(dcm_pkg::MASK_OFFS, 32'h0000_5678);
    for (int i = 0; i < 2; i++) begin
      armed <= (i == 0);
      trace <= (i == 1);
      wr(dcm_pkg::CTRL_OFFS, 32'hff, 4'h1);
      wr(dcm_pkg::DATA_OFFS, 32'h0, 4'hf);
      rdchk(dcm_pkg::CTRL_OFFS, 32'h0);
      rdchk(dcm_pkg::DATA_OFFS, 32'hff00_0000);
    end
    {armed, trace} <= 2'b00;
    wr(dcm_pkg::CTRL_OFFS, 32'hff, 4'h1);
    rdchk(dcm_pkg::CTRL_OFFS, 32'h6d);
    $display("test registers done");
    foreach (modes[i]) begin
      wr(dcm_pkg::CTRL_OFFS, {24'h0, modes[i]}, 4'h1);
      wr(dcm_pkg::DATA_OFFS, $urandom, 4'hf);
      wr(dcm_pkg::MASK_OFFS, $urandom_range(0, 1) ? 32'hffff_ffff : $urandom, 4'hf);
      traffic(150);
    end
    $display("test match modes done");
    give_verdict();
  end
endmodule // tb_dcm_comparator
